// ---- simd_alu_regs.svh ----
/*
 * Named constants of the packed-integer SIMD unit: tag codes, exponent
 * fill, stack-top clear value, control bit positions, identify values
 * and saturation limits.
 * Assumes it is included by bare name from the unit's source files.
 */
`ifndef SIMD_ALU_REGS_SVH
`define SIMD_ALU_REGS_SVH

// Tag codes, one two-bit field per aliased register.
`define TAG_EMPTY 2'b11
`define TAG_VALID 2'b00
`define TAG_RESET 16'hffff

// Exponent field of an aliased register, filled on every packed write.
`define EXP_HI 79
`define EXP_LO 64
`define EXP_ONES 16'hffff

// Stack-top field value after a packed operation other than the empty-state one, and after reset.
`define TOP_CLEAR 3'h0

// Floating-point emulation control bit within control register 0.
`define EMUL_BIT 2

// Identify leaf and the bit that reports the packed-integer unit.
`define FEATURE_LEAF 32'h0000_0001
`define FEATURE_BIT 23

// Signed and unsigned saturation limits.
`define S8_MAX 8'h7f
`define S8_MIN 8'h80
`define S16_MAX 16'h7fff
`define S16_MIN 16'h8000
`define U8_MAX 8'hff
`define U8_MIN 8'h00
`define U16_MAX 16'hffff
`define U16_MIN 16'h0000

`endif

// ---- simd_alu_pkg.sv ----
/*
 * Types of the packed-integer SIMD unit: the operation codes.
 * Assumes the issue logic drives these codes on the op_code port.
 */
package simd_alu_pkg;

  // Operation codes; any other code is refused as an invalid opcode.
  typedef enum logic [5:0] {
    add_wrap_byte, add_wrap_word, add_wrap_dword,
    sub_wrap_byte, sub_wrap_word, sub_wrap_dword,
    add_signed_sat_byte, add_signed_sat_word,
    sub_signed_sat_byte, sub_signed_sat_word,
    add_unsigned_sat_byte, add_unsigned_sat_word,
    sub_unsigned_sat_byte, sub_unsigned_sat_word,
    mul_signed_high_word, mul_signed_low_word, mul_add_pairs,
    cmp_equal_byte, cmp_equal_word, cmp_equal_dword,
    cmp_greater_byte, cmp_greater_word, cmp_greater_dword,
    narrow_signed_word_to_byte, narrow_signed_dword_to_word,
    narrow_word_to_unsigned_byte,
    interleave_high_bytes, interleave_high_words, interleave_high_dwords,
    interleave_low_bytes, interleave_low_words, interleave_low_dwords,
    bitwise_and_quad, bitwise_and_not_quad, bitwise_or_quad,
    bitwise_xor_quad,
    shift_left_logical_word, shift_left_logical_dword,
    shift_left_logical_quad,
    shift_right_logical_word, shift_right_logical_dword,
    shift_right_logical_quad,
    shift_right_arith_word, shift_right_arith_dword,
    empty_packed_state
  } op_t;

endpackage

// ---- packed_integer_simd_alu.sv ----
/*
 * Packed-integer SIMD execution unit with its eight 80-bit registers
 * aliased onto the floating-point register file, the tag word and the
 * stack-top field, plus the identify feature bit.
 * Assumes one issued operation per cycle from the core issue logic, all
 * inputs synchronous to ref_clk, and that the floating-point unit uses
 * the state ports only when no packed operation is issued.
 */
`timescale 1ns/1ps
`include "simd_alu_regs.svh"

module packed_integer_simd_alu (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic issue_valid,
  input wire logic [5:0] op_code,
  input wire logic [2:0] dst_idx,
  input wire logic [2:0] src_idx,
  input wire logic src_use_imm,
  input wire logic [63:0] src_imm,
  input wire logic [31:0] ctrl_word0,
  input wire logic id_req,
  input wire logic [31:0] id_leaf,
  input wire logic fp_wr_en,
  input wire logic [2:0] fp_wr_idx,
  input wire logic [79:0] fp_wr_data,
  input wire logic fp_tag_wr_en,
  input wire logic [15:0] fp_tag_wr_data,
  input wire logic fp_top_wr_en,
  input wire logic [2:0] fp_top_wr_data,
  input wire logic [2:0] state_rd_idx,
  output logic [79:0] state_rd_data,
  output logic [63:0] result,
  output logic done,
  output logic invalid_op,
  output logic [15:0] tag_word,
  output logic [2:0] stack_top_field,
  output logic [31:0] feature_result_word,
  output logic arith_flags_wr_en
);
  import simd_alu_pkg::*;

  // ****************************************************************
  // Storage and state
  // ****************************************************************

  logic [79:0] fp_regs_r [8]; // Shared floating-point and packed store.
  logic [15:0] tag_r; // Tag word, two bits per register.
  logic [2:0] top_r; // Stack-top field of the status word.
  logic [63:0] result_r; // Last packed result.
  logic done_r; // One-cycle completion pulse.
  logic invalid_r; // One-cycle invalid-opcode pulse.
  logic [79:0] rd_data_r; // Registered state read for save.
  logic [31:0] feature_r; // Identify answer.

  logic [63:0] a; // Destination operand.
  logic [63:0] b; // Source operand or shift count.
  logic [63:0] res_nxt; // Computed packed result.
  logic legal_nxt; // Opcode is a supported packed operation.
  logic op_fault; // Issue must be refused.
  logic op_go; // Issue is accepted and writes back.
  logic is_empty_op; // Issue is the empty-state operation.
  op_t op; // Decoded operation.

  assign op = op_t'(op_code);
  assign a = fp_regs_r[dst_idx][63:0];
  assign b = src_use_imm ? src_imm : fp_regs_r[src_idx][63:0];
  assign op_fault = issue_valid &&
                    (!legal_nxt || ctrl_word0[`EMUL_BIT]);
  assign op_go = issue_valid && !op_fault;
  assign is_empty_op = (op == empty_packed_state);

  // Overflow never reaches the status flags, so their write enable
  // stays low whatever the operation does.
  assign arith_flags_wr_en = 1'b0;

  // ****************************************************************
  // Saturation helpers
  // ****************************************************************

  // Clamp a widened signed value to a signed byte.
  function automatic logic [7:0] sat_s8(input logic signed [16:0] v);
    if (v > $signed(17'sd127)) begin
      return `S8_MAX;
    end else if (v < $signed(-17'sd128)) begin
      return `S8_MIN;
    end
    return v[7:0];
  endfunction

  // Clamp a widened signed value to a signed word.
  function automatic logic [15:0] sat_s16(input logic signed [32:0] v);
    if (v > $signed(33'sd32767)) begin
      return `S16_MAX;
    end else if (v < $signed(-33'sd32768)) begin
      return `S16_MIN;
    end
    return v[15:0];
  endfunction

  // Clamp a widened signed value to an unsigned byte.
  function automatic logic [7:0] sat_u8(input logic signed [16:0] v);
    if (v < $signed(17'sd0)) begin
      return `U8_MIN;
    end else if (v > $signed(17'sd255)) begin
      return `U8_MAX;
    end
    return v[7:0];
  endfunction

  // Clamp a widened signed value to an unsigned word.
  function automatic logic [15:0] sat_u16(input logic signed [32:0] v);
    if (v < $signed(33'sd0)) begin
      return `U16_MIN;
    end else if (v > $signed(33'sd65535)) begin
      return `U16_MAX;
    end
    return v[15:0];
  endfunction

  // ****************************************************************
  // Packed datapath
  // ****************************************************************

  // One combinational pass per operation; lanes are loops so all lanes
  // of one element width share one description. Sums are widened before the
  // clamp so the true result is seen, never a wrapped one.
  always_comb begin
    logic [7:0] ab, bb;
    logic [15:0] aw, bw;
    logic [31:0] ad, bd;
    logic signed [31:0] p0, p1;
    res_nxt = 64'h0;
    legal_nxt = 1'b1;
    ab = 8'h0;
    bb = 8'h0;
    aw = 16'h0;
    bw = 16'h0;
    ad = 32'h0;
    bd = 32'h0;
    p0 = 32'sh0;
    p1 = 32'sh0;
    unique case (op)
      add_wrap_byte, sub_wrap_byte, cmp_equal_byte, cmp_greater_byte,
      add_signed_sat_byte, sub_signed_sat_byte,
      add_unsigned_sat_byte, sub_unsigned_sat_byte: begin
        for (int i = 0; i < 8; i++) begin
          ab = a[8*i +: 8];
          bb = b[8*i +: 8];
          unique case (op)
            add_wrap_byte: res_nxt[8*i +: 8] = ab + bb;
            sub_wrap_byte: res_nxt[8*i +: 8] = ab - bb;
            cmp_equal_byte: res_nxt[8*i +: 8] = {8{ab == bb}};
            cmp_greater_byte:
              res_nxt[8*i +: 8] = {8{$signed(ab) > $signed(bb)}};
            add_signed_sat_byte: res_nxt[8*i +: 8] =
              sat_s8({{9{ab[7]}}, ab} + {{9{bb[7]}}, bb});
            sub_signed_sat_byte: res_nxt[8*i +: 8] =
              sat_s8({{9{ab[7]}}, ab} - {{9{bb[7]}}, bb});
            add_unsigned_sat_byte: res_nxt[8*i +: 8] =
              sat_u8({9'h0, ab} + {9'h0, bb});
            default: res_nxt[8*i +: 8] =
              sat_u8({9'h0, ab} - {9'h0, bb});
          endcase
        end
      end
      add_wrap_word, sub_wrap_word, cmp_equal_word, cmp_greater_word,
      add_signed_sat_word, sub_signed_sat_word, add_unsigned_sat_word,
      sub_unsigned_sat_word, mul_signed_high_word,
      mul_signed_low_word: begin
        for (int i = 0; i < 4; i++) begin
          aw = a[16*i +: 16];
          bw = b[16*i +: 16];
          p0 = $signed(aw) * $signed(bw);
          unique case (op)
            add_wrap_word: res_nxt[16*i +: 16] = aw + bw;
            sub_wrap_word: res_nxt[16*i +: 16] = aw - bw;
            cmp_equal_word: res_nxt[16*i +: 16] = {16{aw == bw}};
            cmp_greater_word: res_nxt[16*i +: 16] =
              {16{$signed(aw) > $signed(bw)}};
            add_signed_sat_word: res_nxt[16*i +: 16] =
              sat_s16({{17{aw[15]}}, aw} + {{17{bw[15]}}, bw});
            sub_signed_sat_word: res_nxt[16*i +: 16] =
              sat_s16({{17{aw[15]}}, aw} - {{17{bw[15]}}, bw});
            add_unsigned_sat_word: res_nxt[16*i +: 16] =
              sat_u16({17'h0, aw} + {17'h0, bw});
            sub_unsigned_sat_word: res_nxt[16*i +: 16] =
              sat_u16({17'h0, aw} - {17'h0, bw});
            mul_signed_high_word: res_nxt[16*i +: 16] = p0[31:16];
            default: res_nxt[16*i +: 16] = p0[15:0];
          endcase
        end
      end
      add_wrap_dword, sub_wrap_dword, cmp_equal_dword,
      cmp_greater_dword: begin
        for (int i = 0; i < 2; i++) begin
          ad = a[32*i +: 32];
          bd = b[32*i +: 32];
          unique case (op)
            add_wrap_dword: res_nxt[32*i +: 32] = ad + bd;
            sub_wrap_dword: res_nxt[32*i +: 32] = ad - bd;
            cmp_equal_dword: res_nxt[32*i +: 32] = {32{ad == bd}};
            default: res_nxt[32*i +: 32] =
              {32{$signed(ad) > $signed(bd)}};
          endcase
        end
      end
      mul_add_pairs: begin
        // The sum wraps at 32 bits; only all four inputs at the
        // negative limit can reach that case.
        for (int i = 0; i < 2; i++) begin
          p0 = $signed(a[32*i +: 16]) * $signed(b[32*i +: 16]);
          p1 = $signed(a[32*i+16 +: 16]) * $signed(b[32*i+16 +: 16]);
          res_nxt[32*i +: 32] = p0 + p1;
        end
      end
      narrow_signed_word_to_byte, narrow_word_to_unsigned_byte: begin
        // Destination words fill the low half, source words the high.
        for (int i = 0; i < 4; i++) begin
          aw = a[16*i +: 16];
          bw = b[16*i +: 16];
          if (op == narrow_signed_word_to_byte) begin
            res_nxt[8*i +: 8] = sat_s8({{1{aw[15]}}, aw});
            res_nxt[8*i+32 +: 8] = sat_s8({{1{bw[15]}}, bw});
          end else begin
            res_nxt[8*i +: 8] = sat_u8({{1{aw[15]}}, aw});
            res_nxt[8*i+32 +: 8] = sat_u8({{1{bw[15]}}, bw});
          end
        end
      end
      narrow_signed_dword_to_word: begin
        for (int i = 0; i < 2; i++) begin
          ad = a[32*i +: 32];
          bd = b[32*i +: 32];
          res_nxt[16*i +: 16] = sat_s16({ad[31], ad});
          res_nxt[16*i+32 +: 16] = sat_s16({bd[31], bd});
        end
      end
      interleave_low_bytes, interleave_high_bytes: begin
        for (int i = 0; i < 4; i++) begin
          ab = (op == interleave_high_bytes) ? a[8*i+32 +: 8] : a[8*i +: 8];
          bb = (op == interleave_high_bytes) ? b[8*i+32 +: 8] : b[8*i +: 8];
          res_nxt[16*i +: 16] = {bb, ab};
        end
      end
      interleave_low_words, interleave_high_words: begin
        for (int i = 0; i < 2; i++) begin
          aw = (op == interleave_high_words) ? a[16*i+32 +: 16]
                                             : a[16*i +: 16];
          bw = (op == interleave_high_words) ? b[16*i+32 +: 16]
                                             : b[16*i +: 16];
          res_nxt[32*i +: 32] = {bw, aw};
        end
      end
      interleave_low_dwords: res_nxt = {b[31:0], a[31:0]};
      interleave_high_dwords: res_nxt = {b[63:32], a[63:32]};
      bitwise_and_quad: res_nxt = a & b;
      bitwise_and_not_quad: res_nxt = ~a & b;
      bitwise_or_quad: res_nxt = a | b;
      bitwise_xor_quad: res_nxt = a ^ b;
      shift_left_logical_word, shift_right_logical_word,
      shift_right_arith_word: begin
        // The whole 64-bit count is compared, so a huge count with
        // zero low bits still saturates the shift.
        for (int i = 0; i < 4; i++) begin
          aw = a[16*i +: 16];
          if (op == shift_right_arith_word) begin
            res_nxt[16*i +: 16] = (b > 64'hf) ? {16{aw[15]}}
              : 16'($signed(aw) >>> b[3:0]);
          end else if (b > 64'hf) begin
            res_nxt[16*i +: 16] = 16'h0;
          end else if (op == shift_left_logical_word) begin
            res_nxt[16*i +: 16] = aw << b[3:0];
          end else begin
            res_nxt[16*i +: 16] = aw >> b[3:0];
          end
        end
      end
      shift_left_logical_dword, shift_right_logical_dword,
      shift_right_arith_dword: begin
        for (int i = 0; i < 2; i++) begin
          ad = a[32*i +: 32];
          if (op == shift_right_arith_dword) begin
            res_nxt[32*i +: 32] = (b > 64'h1f) ? {32{ad[31]}}
              : 32'($signed(ad) >>> b[4:0]);
          end else if (b > 64'h1f) begin
            res_nxt[32*i +: 32] = 32'h0;
          end else if (op == shift_left_logical_dword) begin
            res_nxt[32*i +: 32] = ad << b[4:0];
          end else begin
            res_nxt[32*i +: 32] = ad >> b[4:0];
          end
        end
      end
      shift_left_logical_quad:
        res_nxt = (b > 64'h3f) ? 64'h0 : a << b[5:0];
      shift_right_logical_quad:
        res_nxt = (b > 64'h3f) ? 64'h0 : a >> b[5:0];
      empty_packed_state: res_nxt = 64'h0;
      default: legal_nxt = 1'b0;
    endcase
  end

  // ****************************************************************
  // Shared register file
  // ****************************************************************

  // The floating-point port writes the store exactly as given, with no
  // conversion. A packed write in the same cycle lands last and wins;
  // the issue logic is expected never to overlap the two.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        fp_regs_r[i] <= 80'h0;
      end
    end else begin
      if (fp_wr_en) begin
        fp_regs_r[fp_wr_idx] <= fp_wr_data;
      end
      if (op_go && !is_empty_op) begin
        fp_regs_r[dst_idx][63:0] <= res_nxt;
        fp_regs_r[dst_idx][`EXP_HI:`EXP_LO] <= `EXP_ONES;
      end
    end
  end

  // Registered read of one whole register of the shared store for state save; packed
  // contents come out with the floating-point state.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data_r <= 80'h0;
    end else begin
      rd_data_r <= fp_regs_r[state_rd_idx];
    end
  end

  // ****************************************************************
  // Tag word and stack-top field
  // ****************************************************************

  // Tags follow the last packed operation; a floating-point write is
  // taken as found when no packed operation is accepted.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tag_r <= `TAG_RESET;
    end else if (op_go && is_empty_op) begin
      tag_r <= {8{`TAG_EMPTY}};
    end else if (op_go) begin
      tag_r <= {8{`TAG_VALID}};
    end else if (fp_tag_wr_en) begin
      tag_r <= fp_tag_wr_data;
    end
  end

  // The empty-state operation leaves the stack top alone.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      top_r <= `TOP_CLEAR;
    end else if (op_go && !is_empty_op) begin
      top_r <= `TOP_CLEAR;
    end else if (fp_top_wr_en) begin
      top_r <= fp_top_wr_data;
    end
  end

  // ****************************************************************
  // Completion, refusal and identify
  // ****************************************************************

  // A refused issue changes no state; it only raises the fault pulse.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      result_r <= 64'h0;
      done_r <= 1'b0;
      invalid_r <= 1'b0;
    end else begin
      done_r <= op_go;
      invalid_r <= op_fault;
      if (op_go && !is_empty_op) begin
        result_r <= res_nxt;
      end
    end
  end

  // Only leaf one carries the unit's feature bit; other leaves read 0.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      feature_r <= 32'h0;
    end else if (id_req) begin
      feature_r <= 32'h0;
      if (id_leaf == `FEATURE_LEAF) begin
        feature_r[`FEATURE_BIT] <= 1'b1;
      end
    end
  end

  assign state_rd_data = rd_data_r;
  assign result = result_r;
  assign done = done_r;
  assign invalid_op = invalid_r;
  assign tag_word = tag_r;
  assign stack_top_field = top_r;
  assign feature_result_word = feature_r;

endmodule

// ---- simd_alu_chk.sv ----
/* Port checks for the packed integer unit.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module simd_alu_chk
  import simd_alu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic issue_valid,
  input wire logic [5:0] op_code,
  input wire logic [31:0] ctrl_word0,
  input wire logic id_req,
  input wire logic [31:0] id_leaf,
  input wire logic [63:0] result,
  input wire logic done,
  input wire logic invalid_op,
  input wire logic [15:0] tag_word,
  input wire logic [2:0] stack_top_field,
  input wire logic [31:0] feature_result_word,
  input wire logic arith_flags_wr_en
);
  default clocking dck @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Accepted and refused issues, judged at the issue edge.
  logic take;
  logic deny;
  assign take = issue_valid && op_code <= empty_packed_state
    && !ctrl_word0[2];
  assign deny = issue_valid && !take;
  // A mask holds only all-ones or all-zeros bytes.
  function automatic logic is_mask(input logic [63:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      ok = ok && (v[8*i+:8] == 8'h00 || v[8*i+:8] == 8'hff);
    end
    return ok;
  endfunction
  a_accept_done:
    assert property (take |=> done && !invalid_op)
    else $error("accepted issue gave no done pulse");
  a_refuse_pulse:
    assert property (deny |=> invalid_op && !done && $stable(result))
    else $error("refused issue not reported or changed result");
  a_flags_quiet:
    assert property (!arith_flags_wr_en)
    else $error("status flags written by packed operation");
  a_tags_valid:
    assert property (take && op_code != empty_packed_state
      |=> tag_word == 16'h0000)
    else $error("tag word not valid after packed operation");
  a_top_cleared:
    assert property (take && op_code != empty_packed_state
      |=> stack_top_field == 3'h0)
    else $error("stack top not cleared");
  a_tags_empty:
    assert property (take && op_code == empty_packed_state
      |=> tag_word == 16'hffff && $stable(result))
    else $error("empty operation did not empty the tags");
  a_feature_bit:
    assert property (id_req |=> feature_result_word ==
      (($past(id_leaf) == 32'h1) ? 32'h0080_0000 : 32'h0))
    else $error("feature word wrong for leaf");
  a_mask_shape:
    assert property (take && op_code >= cmp_equal_byte
      && op_code <= cmp_greater_dword |=> is_mask(result))
    else $error("compare result is not a mask");
  c_empty: cover property (take && op_code == empty_packed_state);
  c_refused: cover property (deny);
  c_back_to_back: cover property (take ##1 take);
endmodule

bind packed_integer_simd_alu simd_alu_chk u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .issue_valid(issue_valid),
  .op_code(op_code), .ctrl_word0(ctrl_word0), .id_req(id_req),
  .id_leaf(id_leaf), .result(result), .done(done),
  .invalid_op(invalid_op), .tag_word(tag_word),
  .stack_top_field(stack_top_field),
  .feature_result_word(feature_result_word),
  .arith_flags_wr_en(arith_flags_wr_en));

// ---- issue_model.sv ----
/* Model of the core issue logic that feeds the packed unit.
   Assumes one caller; each call drives one clock edge. */
`timescale 1ns/1ps
module issue_model (
  input wire logic ref_clk,
  output logic issue_valid,
  output logic [5:0] op_code,
  output logic [2:0] dst_idx,
  output logic [2:0] src_idx,
  output logic src_use_imm,
  output logic [63:0] src_imm,
  output logic [31:0] ctrl_word0,
  output logic id_req,
  output logic [31:0] id_leaf,
  output logic fp_wr_en,
  output logic [2:0] fp_wr_idx,
  output logic [79:0] fp_wr_data,
  output logic fp_tag_wr_en,
  output logic [15:0] fp_tag_wr_data,
  output logic fp_top_wr_en,
  output logic [2:0] fp_top_wr_data,
  output logic [2:0] state_rd_idx
);
  // Quiet at time zero, so nothing is asked for during reset.
  initial begin
    {issue_valid, op_code, dst_idx, src_idx, src_use_imm, src_imm} = '0;
    {ctrl_word0, id_req, id_leaf, fp_wr_en, fp_wr_idx, fp_wr_data} = '0;
    {fp_tag_wr_en, fp_tag_wr_data, fp_top_wr_en, fp_top_wr_data} = '0;
    state_rd_idx = '0;
  end
  // Strobes s pick issue, fp write, tag, top and identify; v carries
  // every payload so one call can serve any request.
  task automatic drive(input logic [4:0] s, input logic [5:0] c,
      input logic [2:0] d, input logic [79:0] v, input logic em);
    @(posedge ref_clk);
    {issue_valid, fp_wr_en, fp_tag_wr_en, fp_top_wr_en, id_req} <= s;
    op_code <= c;
    dst_idx <= d;
    src_idx <= d + 3'h1;
    src_use_imm <= !v[79];
    src_imm <= v[63:0];
    fp_wr_idx <= d;
    fp_wr_data <= v;
    fp_tag_wr_data <= v[15:0];
    fp_top_wr_data <= v[18:16];
    id_leaf <= v[31:0];
    state_rd_idx <= d;
    ctrl_word0 <= {29'h0, em, 2'h0};
  endtask
endmodule

// ---- test_packed_integer_simd_alu.sv ----
/* Self-checking bench: issues a table of operations on random operands
   and compares each answer in order. Assumes the issue model above. */
`timescale 1ns/1ps
module test_packed_integer_simd_alu;
  import simd_alu_pkg::*;
  typedef struct {logic inv; logic [63:0] res; logic [15:0] tag;} exp_t;
  exp_t q[$];
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic issue_valid, src_use_imm, id_req, fp_wr_en, fp_tag_wr_en;
  logic fp_top_wr_en, done, invalid_op, arith_flags_wr_en;
  logic [5:0] op_code;
  logic [2:0] dst_idx, src_idx, fp_wr_idx, fp_top_wr_data, state_rd_idx;
  logic [2:0] stack_top_field;
  logic [15:0] fp_tag_wr_data, tag_word;
  logic [31:0] ctrl_word0, id_leaf, feature_result_word;
  logic [63:0] src_imm, result;
  logic [79:0] fp_wr_data, state_rd_data;
  logic [63:0] regs [8] = '{default: 64'h0};
  int fails = 0;
  int checks = 0;
  op_t ops [11] = '{add_wrap_byte, sub_unsigned_sat_byte, cmp_greater_byte,
    add_signed_sat_word, mul_signed_high_word, mul_add_pairs,
    narrow_word_to_unsigned_byte, interleave_low_bytes,
    bitwise_and_not_quad, shift_right_arith_word, shift_left_logical_quad};
  always #25 ref_clk = ~ref_clk;
  issue_model iss (.ref_clk(ref_clk), .issue_valid(issue_valid),
    .op_code(op_code), .dst_idx(dst_idx), .src_idx(src_idx),
    .src_use_imm(src_use_imm), .src_imm(src_imm), .ctrl_word0(ctrl_word0),
    .id_req(id_req), .id_leaf(id_leaf), .fp_wr_en(fp_wr_en),
    .fp_wr_idx(fp_wr_idx), .fp_wr_data(fp_wr_data),
    .fp_tag_wr_en(fp_tag_wr_en), .fp_tag_wr_data(fp_tag_wr_data),
    .fp_top_wr_en(fp_top_wr_en), .fp_top_wr_data(fp_top_wr_data),
    .state_rd_idx(state_rd_idx));
  packed_integer_simd_alu DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .issue_valid(issue_valid), .op_code(op_code), .dst_idx(dst_idx),
    .src_idx(src_idx), .src_use_imm(src_use_imm), .src_imm(src_imm),
    .ctrl_word0(ctrl_word0), .id_req(id_req), .id_leaf(id_leaf),
    .fp_wr_en(fp_wr_en), .fp_wr_idx(fp_wr_idx), .fp_wr_data(fp_wr_data),
    .fp_tag_wr_en(fp_tag_wr_en), .fp_tag_wr_data(fp_tag_wr_data),
    .fp_top_wr_en(fp_top_wr_en), .fp_top_wr_data(fp_top_wr_data),
    .state_rd_idx(state_rd_idx), .state_rd_data(state_rd_data),
    .result(result), .done(done), .invalid_op(invalid_op),
    .tag_word(tag_word), .stack_top_field(stack_top_field),
    .feature_result_word(feature_result_word),
    .arith_flags_wr_en(arith_flags_wr_en));
  // Counts one comparison and reports it at once when it misses.
  task automatic cmp(input logic ok, input string m);
    checks++;
    if (!ok) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [7:0] u8(input int v);
    return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
  endfunction
  // Reference result of a with b, lane by lane.
  function automatic logic [63:0] ref_op(input op_t c,
      input logic [63:0] a, input logic [63:0] b);
    logic [63:0] r;
    int x;
    int y;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      x = $signed(a[8*i+:8]);
      y = $signed(b[8*i+:8]);
      case (c)
        add_wrap_byte: r[8*i+:8] = 8'(x + y);
        sub_unsigned_sat_byte: r[8*i+:8] = (a[8*i+:8] < b[8*i+:8]) ?
          8'h00 : 8'(x - y);
        cmp_greater_byte: r[8*i+:8] = (x > y) ? 8'hff : 8'h00;
        default: ;
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      x = $signed(a[16*i+:16]);
      y = $signed(b[16*i+:16]);
      case (c)
        add_signed_sat_word: r[16*i+:16] = (x + y > 32767) ? 16'h7fff :
          (x + y < -32768) ? 16'h8000 : 16'(x + y);
        mul_signed_high_word: r[16*i+:16] = 16'((x * y) >>> 16);
        mul_add_pairs: r[32*(i/2)+:32] += 32'(x * y);
        narrow_word_to_unsigned_byte: begin
          r[8*i+:8] = u8(x);
          r[8*i+32+:8] = u8(y);
        end
        interleave_low_bytes: r[16*i+:16] = {b[8*i+:8], a[8*i+:8]};
        shift_right_arith_word: r[16*i+:16] =
          16'(x >>> ((b > 64'd15) ? 15 : int'(b[3:0])));
        default: ;
      endcase
    end
    if (c == bitwise_and_not_quad) r = ~a & b;
    if (c == shift_left_logical_quad) r = (b > 64'd63) ? '0 : a << b;
    return r;
  endfunction
  // Takes the oldest expectation whenever the unit answers.
  always @(posedge ref_clk) begin
    exp_t e;
    if (done === 1'b1 || invalid_op === 1'b1) begin
      if (q.size() == 0) begin
        cmp(1'b0, "answer with none expected");
      end else begin
        e = q.pop_front();
        cmp(invalid_op === e.inv && done === !e.inv && result === e.res &&
          tag_word === e.tag && stack_top_field === 3'h0, "answer");
      end
    end
  end
  initial begin
    logic [79:0] v;
    logic [63:0] b;
    logic [2:0] d;
    void'($urandom(32'h07e1b869));
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 cmp(tag_word === 16'hffff && result === 64'h0, "reset");
    iss.drive(5'b00110, 6'h0, 3'h0, 80'h5_5a5a, 1'b0);
    iss.drive(5'b00001, 6'h0, 3'h0, 80'h1, 1'b0);
    #1 cmp(tag_word === 16'h5a5a && stack_top_field === 3'h5, "fp");
    iss.drive(5'b00001, 6'h0, 3'h0, 80'h2, 1'b0);
    #1 cmp(feature_result_word === 32'h0080_0000, "leaf one");
    for (int k = 0; k < 44; k++) begin
      d = 3'($urandom);
      v = {16'($urandom), $urandom, $urandom};
      regs[d] = v[63:0];
      iss.drive(5'b01000, ops[k % 11], d, v, 1'b0);
      if (k % 11 > 8) v = {16'h0, 64'($urandom_range(70))};
      b = v[79] ? regs[d + 3'h1] : v[63:0];
      q.push_back(exp_t'{1'b0, ref_op(ops[k % 11], regs[d], b), 16'h0});
      regs[d] = q[$].res;
      iss.drive(5'b10000, ops[k % 11], d, v, 1'b0);
    end
    q.push_back(exp_t'{1'b0, regs[d], 16'hffff});
    iss.drive(5'b10000, empty_packed_state, d, v, 1'b0);
    q.push_back(exp_t'{1'b1, regs[d], 16'hffff});
    iss.drive(5'b10000, 6'h3f, d, v, 1'b0);
    q.push_back(exp_t'{1'b1, regs[d], 16'hffff});
    iss.drive(5'b10000, add_wrap_byte, d, v, 1'b1);
    iss.drive(5'b00000, 6'h0, d, v, 1'b0);
    iss.drive(5'b00000, 6'h0, d, v, 1'b0);
    #1 cmp(state_rd_data === {16'hffff, regs[d]}, "saved");
    cmp(feature_result_word === 32'h0, "leaf two");
    for (int n = 0; n < 8 && q.size() > 0; n++) @(posedge ref_clk);
    cmp(q.size() == 0, "answers missing");
    wrap_up();
  end
endmodule
